// ### core/bmc_pkg.sv
// Constants shared by the motor control core: register map, fields, resets.
// Assumes a 20 MHz system clock and an Avalon-MM master with 32-bit data.
// Function
// - Six drive modes: u-y, u-z, v-z, v-x, w-x, w-y; others off.
// - In each mode one transistor is PWM modulated, the other held on.
// - Mode time is the interval between successive position detects.
// - Commutation fires half a mode time after each detect.
// - Detection window restarts three quarters of a mode time later.
// - Failure event if no detect within twice the mode time.
// - One magnitude and two coincidence comparators share the mode timer.
// - Next pattern is double buffered, applied on detect or timer event.
// - Match needs a programmed repeat count; inhibit after PWM turn-on.
// - PWM duty is 12 bits, one count per PWM clock.
// - PWM interrupt fires once per programmed number of periods plus one.
// - Dead time after each PWM edge, for the modulated pair only; optional single-sided PWM.
// - Overcurrent input cuts all gate drives while it is active.
// - Emergency input latches gates off; cleared by a two-key write.
// - Angle counter spans 0..383 and addresses a 384-entry sine table.
// - Sine entries at the current angle plus 0, 128 and 256 feed the u, v, w duty arithmetic.
// - Phase duty is computed from amplitude times sine data.
// - Duty can instead use sine values from a waveform register.
// - Full-scale amplitude gives 100 percent duty.
// - Detect irq when inputs equal expected pattern; sampling stops.
package bmc_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_PERIOD = 6'h04;
    localparam logic [5:0] OFS_DUTY = 6'h08;
    localparam logic [5:0] OFS_DEAD = 6'h0C;
    localparam logic [5:0] OFS_PATTERN = 6'h10;
    localparam logic [5:0] OFS_DETECT = 6'h14;
    localparam logic [5:0] OFS_STATUS = 6'h18;
    localparam logic [5:0] OFS_MTIME = 6'h1C;
    localparam logic [5:0] OFS_KEY = 6'h20;
    localparam logic [5:0] OFS_IRQRATE = 6'h24;
    localparam logic [5:0] OFS_ANGLE = 6'h28;
    localparam logic [5:0] OFS_AMP = 6'h2C;
    localparam logic [5:0] OFS_TABLE = 6'h30;
    localparam logic [5:0] OFS_WAVE = 6'h34;
    // Control bits
    localparam int CTL_EN = 0;
    localparam int CTL_PWM_LO = 1;
    localparam int CTL_SINGLE = 2;
    localparam int CTL_ANG_DN = 3;
    localparam int CTL_ANG_EN = 4;
    localparam int CTL_WAVE_REG = 5;
    localparam int CTL_CMT_DET = 6;
    localparam int CTL_AUTO_ST = 7;
    // Detect register fields
    localparam int DET_REP_LSB = 0;
    localparam int DET_INH_LSB = 4;
    localparam int DET_START = 31;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [11:0] RST_PERIOD = 12'h3FF;
    localparam logic [11:0] RST_DUTY = 12'h000;
    localparam logic [7:0] RST_DEAD = 8'h04;
    localparam logic [3:0] RST_REP = 4'h1;
    localparam logic [7:0] RST_INH = 8'h00;
    // Angle and table
    localparam logic [8:0] ANG_MAX = 9'h17F;
    localparam int TBL_DEPTH = 384;
    localparam logic [8:0] PH_OFS_V = 9'h080;
    localparam logic [8:0] PH_OFS_W = 9'h100;
    localparam logic [15:0] AMP_FULL = 16'hFFFF;
    // Emergency release keys
    localparam logic [7:0] KEY_ONE = 8'h5A;
    localparam logic [7:0] KEY_TWO = 8'hA5;
endpackage

// ### core/bmc_core.sv
// Motor control core: six-step drive, PWM with dead time, mode timer,
// position detection, protection, electrical angle and sine duty.
// Assumes pins arrive asynchronously and the PWM clock is i_mclk.
`timescale 1ns/1ps
module bmc_core #(
    parameter int MT_W = 16
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Avalon-MM slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Motor pins
    input wire logic [2:0] i_pos,
    input wire logic i_overcurrent_limit_input,
    input wire logic i_emergency_stop_input,
    output logic [5:0] o_gate,
    // Events and duty results
    output logic o_position_match_irq,
    output logic o_fail_evt,
    output logic o_pwm_irq,
    output logic [11:0] o_duty_u,
    output logic [11:0] o_duty_v,
    output logic [11:0] o_duty_w
);
    generate
        if (MT_W < 8 || MT_W > 30) begin : g_chk
            $error("MT_W out of range");
        end
    endgenerate

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [11:0] period;
        logic [11:0] duty;
        logic [7:0] dead;
        logic [2:0] buf_mode;
        logic [2:0] buf_exp;
        logic [2:0] cur_mode;
        logic [2:0] exp;
        logic [3:0] rep;
        logic [7:0] inh;
        logic [3:0] rate;
        logic [15:0] amp;
        logic [23:0] wave;
        logic key1;
        logic estop;
        logic [8:0] angle;
        logic [11:0] pcnt;
        logic pprev;
        logic [7:0] dtc;
        logic [7:0] inhc;
        logic [3:0] rcnt;
        logic [3:0] irqc;
        logic [MT_W-1:0] timer;
        logic [MT_W-1:0] mtime;
        logic sampling;
        logic failed;
        logic [5:0] gates;
        logic irq_pdc;
        logic irq_fail;
        logic irq_pwm;
        logic [11:0] duty_u;
        logic [11:0] duty_v;
        logic [11:0] duty_w;
        logic [2:0] pos_s1;
        logic [2:0] pos_s2;
        logic ocl_s1;
        logic ocl_s2;
        logic est_s1;
        logic est_s2;
    } bmc_state_s;

    bmc_state_s st_ff;
    bmc_state_s nxt_st;
    logic [7:0] sine_ram [bmc_pkg::TBL_DEPTH];
    logic req;
    logic wr;
    logic [31:0] rd_mux;
    logic pwm_on;
    logic dt_done;
    logic on_ok;
    logic comp_ok;
    logic period_start;
    logic cmt_evt;
    logic start_evt;
    logic fail_evt;
    logic match;
    logic det_evt;
    logic drive;
    logic [MT_W-1:0] half_t;
    logic [MT_W-1:0] tq_t;
    logic [MT_W:0] two_t;
    logic [1:0] up_ph;
    logic [1:0] lo_ph;
    logic [5:0] g;
    logic [8:0] ang_v;
    logic [8:0] ang_w;

    function automatic logic [8:0] ang_add(input logic [8:0] a,
                                           input logic [8:0] o);
        logic [9:0] t;
        t = {1'b0, a} + {1'b0, o};
        if (t > {1'b0, bmc_pkg::ANG_MAX}) begin
            t = t - 10'(bmc_pkg::TBL_DEPTH);
        end
        return t[8:0];
    endfunction

    // Result saturates at the period so a large amplitude means full on
    function automatic logic [11:0] calc_duty(input logic [7:0] sn,
                                              input logic [15:0] amp,
                                              input logic [11:0] per);
        logic [23:0] p;
        p = 24'(sn) * 24'(amp);
        if (amp == bmc_pkg::AMP_FULL || p[23:8] >= 16'(per)) begin
            return per;
        end
        return p[19:8];
    endfunction

    assign req = i_avs_read | i_avs_write;
    assign wr = i_avs_write & st_ff.ack;
    assign o_avs_waitrequest = req & ~st_ff.ack;
    assign o_avs_readdata = st_ff.rdata;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_avs_address)
            bmc_pkg::OFS_CTRL: rd_mux[7:0] = st_ff.ctrl;
            bmc_pkg::OFS_PERIOD: rd_mux[11:0] = st_ff.period;
            bmc_pkg::OFS_DUTY: rd_mux[11:0] = st_ff.duty;
            bmc_pkg::OFS_DEAD: rd_mux[7:0] = st_ff.dead;
            bmc_pkg::OFS_PATTERN: rd_mux[5:0] = {st_ff.buf_exp,
                                                 st_ff.buf_mode};
            bmc_pkg::OFS_DETECT: rd_mux[11:0] = {st_ff.inh, st_ff.rep};
            bmc_pkg::OFS_STATUS: rd_mux[15:0] = {st_ff.pos_s2, st_ff.exp,
                st_ff.ocl_s2, st_ff.failed, st_ff.estop, st_ff.sampling,
                1'b0, st_ff.cur_mode};
            bmc_pkg::OFS_MTIME: rd_mux[MT_W-1:0] = st_ff.mtime;
            bmc_pkg::OFS_IRQRATE: rd_mux[3:0] = st_ff.rate;
            bmc_pkg::OFS_ANGLE: rd_mux[8:0] = st_ff.angle;
            bmc_pkg::OFS_AMP: rd_mux[15:0] = st_ff.amp;
            bmc_pkg::OFS_WAVE: rd_mux[23:0] = st_ff.wave;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Sine table; bus writes carry the index in [8:0], data in [23:16]
    always_ff @(posedge i_mclk) begin
        if (wr && i_avs_address == bmc_pkg::OFS_TABLE &&
            i_avs_writedata[8:0] <= bmc_pkg::ANG_MAX) begin
            sine_ram[i_avs_writedata[8:0]] <= i_avs_writedata[23:16];
        end
    end

    assign ang_v = ang_add(st_ff.angle, bmc_pkg::PH_OFS_V);
    assign ang_w = ang_add(st_ff.angle, bmc_pkg::PH_OFS_W);
    assign period_start = (st_ff.pcnt == 12'h000);
    assign pwm_on = st_ff.pcnt < st_ff.duty;
    assign dt_done = st_ff.dtc >= st_ff.dead;
    assign on_ok = st_ff.pprev & dt_done;
    assign comp_ok = ~st_ff.pprev & dt_done &
                     ~st_ff.ctrl[bmc_pkg::CTL_SINGLE];
    assign half_t = st_ff.mtime >> 1;
    assign tq_t = (st_ff.mtime >> 1) + (st_ff.mtime >> 2);
    assign two_t = {st_ff.mtime, 1'b0};
    // Two coincidence events and one magnitude event off one timer
    assign cmt_evt = st_ff.ctrl[bmc_pkg::CTL_EN] &&
        st_ff.mtime != '0 && st_ff.timer == half_t;
    assign start_evt = st_ff.ctrl[bmc_pkg::CTL_EN] &&
        st_ff.mtime != '0 && st_ff.timer == tq_t;
    assign fail_evt = st_ff.ctrl[bmc_pkg::CTL_EN] && st_ff.mtime != '0 &&
        {1'b0, st_ff.timer} >= two_t && !st_ff.failed;
    assign match = st_ff.sampling && st_ff.inhc == 8'h00 &&
                   st_ff.pos_s2 == st_ff.exp;
    assign det_evt = match && (st_ff.rcnt + 4'h1 >= st_ff.rep);
    assign drive = st_ff.ctrl[bmc_pkg::CTL_EN] & ~st_ff.estop &
                   ~st_ff.est_s2 & ~st_ff.ocl_s2;

    always_comb begin
        up_ph = 2'd3;
        lo_ph = 2'd3;
        case (st_ff.cur_mode)
            3'd0: begin up_ph = 2'd0; lo_ph = 2'd1; end
            3'd1: begin up_ph = 2'd0; lo_ph = 2'd2; end
            3'd2: begin up_ph = 2'd1; lo_ph = 2'd2; end
            3'd3: begin up_ph = 2'd1; lo_ph = 2'd0; end
            3'd4: begin up_ph = 2'd2; lo_ph = 2'd0; end
            3'd5: begin up_ph = 2'd2; lo_ph = 2'd1; end
            default: begin up_ph = 2'd3; lo_ph = 2'd3; end
        endcase
        g = 6'h00;
        if (up_ph != 2'd3 && drive) begin
            // Modulated side plus its complementary leg transistor
            if (!st_ff.ctrl[bmc_pkg::CTL_PWM_LO]) begin
                g[up_ph] = on_ok;
                g[3 + lo_ph] = 1'b1;
                g[3 + up_ph] = comp_ok;
            end else begin
                g[up_ph] = 1'b1;
                g[3 + lo_ph] = on_ok;
                g[lo_ph] = comp_ok;
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq_pdc = 1'b0;
        nxt_st.irq_fail = 1'b0;
        nxt_st.irq_pwm = 1'b0;
        nxt_st.gates = g;
        nxt_st.pos_s1 = i_pos;
        nxt_st.pos_s2 = st_ff.pos_s1;
        nxt_st.ocl_s1 = i_overcurrent_limit_input;
        nxt_st.ocl_s2 = st_ff.ocl_s1;
        nxt_st.est_s1 = i_emergency_stop_input;
        nxt_st.est_s2 = st_ff.est_s1;
        nxt_st.ack = req & ~st_ff.ack;
        if (req && !st_ff.ack) begin
            nxt_st.rdata = rd_mux;
        end
        // PWM counter, dead time and inhibit window
        if (st_ff.pcnt + 12'h001 >= st_ff.period) begin
            nxt_st.pcnt = 12'h000;
        end else begin
            nxt_st.pcnt = st_ff.pcnt + 12'h001;
        end
        nxt_st.pprev = pwm_on;
        if (pwm_on != st_ff.pprev) begin
            nxt_st.dtc = 8'h00;
        end else if (!dt_done) begin
            nxt_st.dtc = st_ff.dtc + 8'h01;
        end
        if (pwm_on && !st_ff.pprev) begin
            nxt_st.inhc = st_ff.inh;
        end else if (st_ff.inhc != 8'h00) begin
            nxt_st.inhc = st_ff.inhc - 8'h01;
        end
        if (period_start) begin
            if (st_ff.irqc >= st_ff.rate) begin
                nxt_st.irqc = 4'h0;
                nxt_st.irq_pwm = st_ff.ctrl[bmc_pkg::CTL_EN];
            end else begin
                nxt_st.irqc = st_ff.irqc + 4'h1;
            end
            if (st_ff.ctrl[bmc_pkg::CTL_ANG_EN]) begin
                if (st_ff.ctrl[bmc_pkg::CTL_ANG_DN]) begin
                    nxt_st.angle = (st_ff.angle == 9'h000) ?
                        bmc_pkg::ANG_MAX : st_ff.angle - 9'h001;
                end else begin
                    nxt_st.angle = (st_ff.angle >= bmc_pkg::ANG_MAX) ?
                        9'h000 : st_ff.angle + 9'h001;
                end
            end
            if (st_ff.ctrl[bmc_pkg::CTL_WAVE_REG]) begin
                nxt_st.duty_u = calc_duty(st_ff.wave[7:0], st_ff.amp,
                                          st_ff.period);
                nxt_st.duty_v = calc_duty(st_ff.wave[15:8], st_ff.amp,
                                          st_ff.period);
                nxt_st.duty_w = calc_duty(st_ff.wave[23:16], st_ff.amp,
                                          st_ff.period);
            end else begin
                nxt_st.duty_u = calc_duty(sine_ram[st_ff.angle],
                                          st_ff.amp, st_ff.period);
                nxt_st.duty_v = calc_duty(sine_ram[ang_v], st_ff.amp,
                                          st_ff.period);
                nxt_st.duty_w = calc_duty(sine_ram[ang_w], st_ff.amp,
                                          st_ff.period);
            end
        end
        // Register writes
        if (wr) begin
            case (i_avs_address)
                bmc_pkg::OFS_CTRL: nxt_st.ctrl = i_avs_writedata[7:0];
                bmc_pkg::OFS_PERIOD: nxt_st.period = i_avs_writedata[11:0];
                bmc_pkg::OFS_DUTY: nxt_st.duty = i_avs_writedata[11:0];
                bmc_pkg::OFS_DEAD: nxt_st.dead = i_avs_writedata[7:0];
                bmc_pkg::OFS_PATTERN: begin
                    nxt_st.buf_mode = i_avs_writedata[2:0];
                    nxt_st.buf_exp = i_avs_writedata[5:3];
                end
                bmc_pkg::OFS_DETECT: begin
                    nxt_st.rep = i_avs_writedata[bmc_pkg::DET_REP_LSB +: 4];
                    nxt_st.inh = i_avs_writedata[bmc_pkg::DET_INH_LSB +: 8];
                    if (i_avs_writedata[bmc_pkg::DET_START]) begin
                        nxt_st.sampling = 1'b1;
                        nxt_st.rcnt = 4'h0;
                    end
                end
                bmc_pkg::OFS_IRQRATE: nxt_st.rate = i_avs_writedata[3:0];
                bmc_pkg::OFS_ANGLE: begin
                    if (i_avs_writedata[8:0] <= bmc_pkg::ANG_MAX) begin
                        nxt_st.angle = i_avs_writedata[8:0];
                    end
                end
                bmc_pkg::OFS_AMP: nxt_st.amp = i_avs_writedata[15:0];
                bmc_pkg::OFS_WAVE: nxt_st.wave = i_avs_writedata[23:0];
                default: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // Emergency release only by two keys in a row and a calm pin
        if (wr && i_avs_address == bmc_pkg::OFS_KEY) begin
            nxt_st.key1 = (i_avs_writedata[7:0] == bmc_pkg::KEY_ONE);
            if (st_ff.key1 && !st_ff.est_s2 &&
                i_avs_writedata[7:0] == bmc_pkg::KEY_TWO) begin
                nxt_st.estop = 1'b0;
            end
        end else if (wr) begin
            nxt_st.key1 = 1'b0;
        end
        if (st_ff.est_s2) begin
            nxt_st.estop = 1'b1;
        end
        // Mode timer and position detection
        if (st_ff.ctrl[bmc_pkg::CTL_EN] && st_ff.timer != '1) begin
            nxt_st.timer = st_ff.timer + 1'b1;
        end
        if (cmt_evt && !st_ff.ctrl[bmc_pkg::CTL_CMT_DET]) begin
            nxt_st.cur_mode = st_ff.buf_mode;
            nxt_st.exp = st_ff.buf_exp;
        end
        if (start_evt && st_ff.ctrl[bmc_pkg::CTL_AUTO_ST]) begin
            nxt_st.sampling = 1'b1;
            nxt_st.rcnt = 4'h0;
        end
        if (fail_evt) begin
            nxt_st.failed = 1'b1;
            nxt_st.irq_fail = 1'b1;
        end
        if (st_ff.sampling && st_ff.inhc == 8'h00 && !match) begin
            nxt_st.rcnt = 4'h0;
        end else if (match && !det_evt) begin
            nxt_st.rcnt = st_ff.rcnt + 4'h1;
        end
        if (det_evt) begin
            nxt_st.irq_pdc = 1'b1;
            nxt_st.sampling = 1'b0;
            nxt_st.rcnt = 4'h0;
            nxt_st.mtime = st_ff.timer;
            nxt_st.timer = '0;
            nxt_st.failed = 1'b0;
            if (st_ff.ctrl[bmc_pkg::CTL_CMT_DET]) begin
                nxt_st.cur_mode = st_ff.buf_mode;
                nxt_st.exp = st_ff.buf_exp;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
            st_ff.ctrl <= bmc_pkg::RST_CTRL;
            st_ff.period <= bmc_pkg::RST_PERIOD;
            st_ff.duty <= bmc_pkg::RST_DUTY;
            st_ff.dead <= bmc_pkg::RST_DEAD;
            st_ff.rep <= bmc_pkg::RST_REP;
            st_ff.inh <= bmc_pkg::RST_INH;
            st_ff.cur_mode <= 3'd7;
            st_ff.buf_mode <= 3'd7;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_gate = st_ff.gates;
    assign o_position_match_irq = st_ff.irq_pdc;
    assign o_fail_evt = st_ff.irq_fail;
    assign o_pwm_irq = st_ff.irq_pwm;
    assign o_duty_u = st_ff.duty_u;
    assign o_duty_v = st_ff.duty_v;
    assign o_duty_w = st_ff.duty_w;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_leg_exclusive: assert property (
        !(o_gate[0] && o_gate[3]) && !(o_gate[1] && o_gate[4]) &&
        !(o_gate[2] && o_gate[5]))
        else $error("upper and lower of one leg both on");
    a_lower_held: assert property (
        drive && st_ff.cur_mode == 3'd0 && !st_ff.ctrl[bmc_pkg::CTL_PWM_LO]
        |=> o_gate[4]) else $error("held lower transistor dropped");
    a_mode_time: assert property (
        det_evt |=> st_ff.mtime == $past(st_ff.timer) && st_ff.timer == '0)
        else $error("mode time not captured");
    a_commut_apply: assert property (
        cmt_evt && !st_ff.ctrl[bmc_pkg::CTL_CMT_DET] && !det_evt
        |=> st_ff.cur_mode == $past(st_ff.buf_mode))
        else $error("commutation did not load buffered mode");
    a_detect_start: assert property (
        start_evt && st_ff.ctrl[bmc_pkg::CTL_AUTO_ST] && !det_evt
        |=> st_ff.sampling) else $error("detection window not opened");
    a_fail_timing: assert property (
        o_fail_evt |-> {1'b0, $past(st_ff.timer)} >= $past(two_t))
        else $error("failure raised early");
    a_inhibit_block: assert property (
        st_ff.inhc != 8'h00 |=> !o_position_match_irq)
        else $error("detect during inhibit");
    a_overcurrent_off: assert property (
        st_ff.ocl_s2 |=> o_gate == 6'h00) else $error("gates on in overcurrent");
    a_estop_hold: assert property (
        st_ff.est_s2 |=> ##1 o_gate == 6'h00 [*3])
        else $error("gates on after emergency");
    a_angle_range: assert property (
        st_ff.angle <= bmc_pkg::ANG_MAX) else $error("angle out of range");
    a_angle_wrap: assert property (
        period_start && st_ff.ctrl[bmc_pkg::CTL_ANG_EN] &&
        !st_ff.ctrl[bmc_pkg::CTL_ANG_DN] && st_ff.angle == bmc_pkg::ANG_MAX &&
        !wr |=> st_ff.angle == 9'h000) else $error("angle did not wrap");
    a_sample_stop: assert property (
        o_position_match_irq |-> !st_ff.sampling ||
        $past(st_ff.ctrl[bmc_pkg::CTL_AUTO_ST]) || $past(wr))
        else $error("sampling continued after detect");
    a_bus_answer: assert property (
        req && !st_ff.ack |=> !o_avs_waitrequest || !req)
        else $error("bus answer late");

    c_detect: cover property (o_position_match_irq);
    c_commutate: cover property (cmt_evt ##1 o_gate != 6'h00);
    c_fail: cover property (o_fail_evt);
    c_estop: cover property (st_ff.estop ##[1:50] !st_ff.estop);
endmodule

// ### bench/bmc_inverter.sv
// Inverter bridge and rotor sensor model facing the motor control core.
// Assumes gate order u,v,w upper then x,y,z lower, high = switch on.
`timescale 1ns/1ps
module bmc_inverter (
    // Gates and rotor sector
    input wire logic i_mclk,
    input wire logic [5:0] i_gate,
    input wire logic [2:0] i_rotor,
    // Sensor lines and short flag
    output logic [2:0] o_pos,
    output logic o_shoot
);
    // Sensors are push-pull, so they always show the rotor sector
    assign o_pos = i_rotor;
    initial o_shoot = 1'b0;
    // A leg with both switches on shorts the supply; it stays flagged
    always @(posedge i_mclk) begin
        if ((i_gate[2:0] & i_gate[5:3]) != 3'h0) begin
            o_shoot <= 1'b1;
        end
    end
endmodule

// ### bench/bmc_testbench.sv
// Self-checking bench: bus, six drive modes, protection, angle wrap.
// Assumes the core answers Avalon requests after one wait state.
`timescale 1ns/1ps
module testbench;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, got;
    logic wait_s, irq, shoot, oc = 1'b0, estop = 1'b0;
    logic [2:0] rotor = 3'h0;
    logic [2:0] pos;
    logic [5:0] gate;
    logic fev, pirq;
    logic [11:0] du, dv, dw;
    int since = 0;
    int gap = 0;
    int n_fail = 0;
    int checks_done = 0;
    always #25 i_mclk = ~i_mclk;
    // Cycles since the last detect pulse, and the spacing of the last two
    always @(posedge i_mclk) begin
        if (irq === 1'b1) gap <= since;
        since <= (irq === 1'b1) ? 0 : since + 1;
    end
    bmc_core bmc_core_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_s), .i_pos(pos),
        .i_overcurrent_limit_input(oc), .i_emergency_stop_input(estop),
        .o_gate(gate), .o_position_match_irq(irq), .o_fail_evt(fev),
        .o_pwm_irq(pirq), .o_duty_u(du), .o_duty_v(dv), .o_duty_w(dw));
    bmc_inverter bmc_inverter_inst (.i_mclk(i_mclk), .i_gate(gate),
        .i_rotor(rotor), .o_pos(pos), .o_shoot(shoot));
    task chk(input string what, input logic [31:0] exp, input logic [31:0] g);
        checks_done++;
        if (g !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, g);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdat <= d;
        wr_s <= w;
        rd_s <= ~w;
        do @(posedge i_mclk); while (wait_s !== 1'b0);
        got = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task t_reset;
        bus(1'b0, bmc_pkg::OFS_PERIOD, 32'h0);
        chk("period", {20'h0, bmc_pkg::RST_PERIOD}, got);
        bus(1'b0, bmc_pkg::OFS_DEAD, 32'h0);
        chk("dead", {24'h0, bmc_pkg::RST_DEAD}, got);
        bus(1'b0, 6'h38, 32'h0);
        chk("unmapped", 32'h0, got);
        $display("test reset done");
    endtask
    task t_modes;
        logic [2:0] pt [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
        logic [5:0] lo [6] = '{6'h10, 6'h20, 6'h20, 6'h08, 6'h08, 6'h10};
        logic [5:0] up, on, off;
        logic bad;
        int k;
        logic [2:0] ex;
        ex = 3'h0;
        bus(1'b1, bmc_pkg::OFS_PERIOD, 32'h20);
        bus(1'b1, bmc_pkg::OFS_DUTY, 32'h10);
        // Single-sided so the modulated leg's partner stays off
        bus(1'b1, bmc_pkg::OFS_CTRL, 32'h45);
        for (int m = 0; m < 6; m++) begin
            up = 6'h01 << (m / 2);
            // Detect compares against the pattern made current last time
            rotor <= ~ex;
            bus(1'b1, bmc_pkg::OFS_PATTERN, {26'h0, pt[m], m[2:0]});
            bus(1'b1, bmc_pkg::OFS_DETECT, 32'h80000001);
            rotor <= ex;
            k = 0;
            while (irq !== 1'b1 && k < 100) begin
                @(posedge i_mclk);
                k++;
            end
            chk("detect irq", 32'h1, {31'h0, irq});
            repeat (4) @(posedge i_mclk);
            bad = 1'b0;
            on = 6'h0;
            off = 6'h0;
            repeat (80) begin
                @(negedge i_mclk);
                if ((gate & ~up) !== lo[m]) bad = 1'b1;
                on = on | (gate & up);
                off = off | (~gate & up);
            end
            chk("held gates", 32'h0, bad);
            chk("pwm toggles", {26'h0, up}, {26'h0, on & off});
            ex = pt[m];
        end
        bus(1'b0, bmc_pkg::OFS_MTIME, 32'h0);
        chk("mode time", gap, got);
        k = 0;
        while (fev !== 1'b1 && k < 400) begin
            @(posedge i_mclk);
            k++;
        end
        chk("fail delay", {got[30:0], 1'b0}, since);
        chk("shoot through", 32'h0, {31'h0, shoot});
        $display("test modes done");
    endtask
    task t_protect;
        logic bad;
        @(posedge i_mclk);
        oc <= 1'b1;
        repeat (4) @(posedge i_mclk);
        bad = 1'b0;
        repeat (20) begin
            @(negedge i_mclk);
            if (gate !== 6'h0) bad = 1'b1;
        end
        chk("overcurrent off", 32'h0, {31'h0, bad});
        @(posedge i_mclk);
        oc <= 1'b0;
        repeat (6) @(posedge i_mclk);
        chk("overcurrent back", 32'h10, gate & 6'h38);
        estop <= 1'b1;
        repeat (4) @(posedge i_mclk);
        estop <= 1'b0;
        repeat (10) @(posedge i_mclk);
        chk("estop latched", 32'h0, gate);
        bus(1'b1, bmc_pkg::OFS_KEY, {24'h0, bmc_pkg::KEY_ONE});
        bus(1'b1, bmc_pkg::OFS_KEY, {24'h0, bmc_pkg::KEY_TWO});
        repeat (6) @(posedge i_mclk);
        chk("estop cleared", 32'h10, gate & 6'h38);
        $display("test protect done");
    endtask
    task t_angle;
        int k;
        bus(1'b1, bmc_pkg::OFS_PERIOD, 32'h10);
        bus(1'b1, bmc_pkg::OFS_ANGLE, 32'h17F);
        bus(1'b1, bmc_pkg::OFS_CTRL, 32'h55);
        for (k = 0, got = 32'h17F; got == 32'h17F && k < 40; k++)
            bus(1'b0, bmc_pkg::OFS_ANGLE, 32'h0);
        chk("angle up wrap", 32'h0, got);
        bus(1'b1, bmc_pkg::OFS_CTRL, 32'h5D);
        bus(1'b1, bmc_pkg::OFS_ANGLE, 32'h0);
        for (k = 0, got = 32'h0; got == 32'h0 && k < 40; k++)
            bus(1'b0, bmc_pkg::OFS_ANGLE, 32'h0);
        chk("angle down wrap", 32'h17F, got);
        $display("test angle done");
    endtask
    task t_duty;
        int n;
        logic z_on;
        n = 0;
        z_on = 1'b0;
        bus(1'b1, bmc_pkg::OFS_PERIOD, 32'h40);
        bus(1'b1, bmc_pkg::OFS_AMP, 32'h100);
        bus(1'b1, bmc_pkg::OFS_WAVE, 32'h302010);
        bus(1'b1, bmc_pkg::OFS_IRQRATE, 32'h1);
        // Complementary PWM, duties from the wave register
        bus(1'b1, bmc_pkg::OFS_CTRL, 32'h21);
        repeat (200) @(posedge i_mclk);
        chk("duty u", 32'h10, {20'h0, du});
        chk("duty v", 32'h20, {20'h0, dv});
        chk("duty w", 32'h30, {20'h0, dw});
        repeat (256) begin
            @(posedge i_mclk);
            if (pirq === 1'b1) n++;
            if (gate[5] === 1'b1) z_on = 1'b1;
        end
        chk("pwm irq count", 32'h2, n);
        chk("partner leg on", 32'h1, {31'h0, z_on});
        bus(1'b1, bmc_pkg::OFS_AMP, 32'hFFFF);
        repeat (70) @(posedge i_mclk);
        chk("duty full", 32'h40, {20'h0, du});
        bus(1'b1, bmc_pkg::OFS_CTRL, 32'h0);
        repeat (3) @(posedge i_mclk);
        chk("stopped gates", 32'h0, {26'h0, gate});
        chk("shoot through", 32'h0, {31'h0, shoot});
        $display("test duty done");
    endtask
    initial begin
        // Bounds the whole run at about 40000 cycles
        #2000000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_reset;
        t_modes;
        t_protect;
        t_angle;
        t_duty;
        report_and_stop;
    end
endmodule
